// ==== logic/bridge_defines.svh ====
// Purpose: Constants for the dual network I/O data bridge.
// Assumes: A 100 MHz pclk.
// Notes:   Offsets are APB byte addresses.
`ifndef BRIDGE_DEFINES_SVH
`define BRIDGE_DEFINES_SVH

// Register byte offsets.
`define REG_LEN_AB      8'h00
`define REG_LEN_BA      8'h04
`define REG_STATUS      8'h08
`define REG_COUNT       8'h0C

// Transfer sizes in bytes.
`define MAX_LEN         8'h80
`define LEN_FIX4        8'h04
`define LEN_FIX16       8'h10
`define LEN_FIX32       8'h20
`define LEN_FIX128      8'h80
`define LEN_RESET       8'h00

// Size selector codes; every code from SW upward means software sizing.
`define SIZE_SEL_4      3'h0
`define SIZE_SEL_16     3'h1
`define SIZE_SEL_32     3'h2
`define SIZE_SEL_128    3'h3
`define SIZE_SEL_SW     3'h4

// Bit rate detection timing.
`define CLK_PERIOD_NS   10
`define BAUD_SLOW_NS    6000
`define BAUD_MID_NS     3000
`define BAUD_SLOW_CYC   (`BAUD_SLOW_NS / `CLK_PERIOD_NS)
`define BAUD_MID_CYC    (`BAUD_MID_NS / `CLK_PERIOD_NS)
`define BAUD_EDGES      5'h10
`define RUN_MAX         11'h7FF

`endif

// ==== logic/bridge_pkg.sv ====
// Purpose: Types shared by the bridge modules.
// Assumes: bridge_defines.svh provides the sizes.
// Notes:   Side index 0 is network A, index 1 is network B.
package bridge_pkg;
`include "bridge_defines.svh"

    typedef enum logic [1:0] {
        BD_WAIT = 2'b00,
        BD_MEAS = 2'b01,
        BD_DONE = 2'b11
    } baud_state_t;

    typedef enum logic [1:0] {
        RATE_125K = 2'b00,
        RATE_250K = 2'b01,
        RATE_500K = 2'b11,
        RATE_NONE = 2'b10
    } rate_t;

    typedef struct packed {
        logic [1:0][127:0][7:0] img;
        logic [1:0][7:0]        wptr;
        logic [1:0][15:0]       msg_cnt;
        logic [1:0][7:0]        len_sw;
        logic [2:0]             size_s1;
        logic [2:0]             size_s2;
        logic [1:0][5:0]        node_s1;
        logic [1:0][5:0]        node_s2;
        logic [1:0][5:0]        node;
        logic [1:0]             pin_s1;
        logic [1:0]             pin_s2;
        logic [1:0]             pin_prev;
        baud_state_t [1:0]      bd_st;
        logic [1:0][10:0]       run;
        logic [1:0][10:0]       run_min;
        logic [1:0][4:0]        edges;
        rate_t [1:0]            rate;
        logic [1:0][7:0]        rd_data;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } bridge_state_t;

endpackage

// ==== logic/fifo_if.sv ====
// Purpose: Valid/ready carrier between the bridge and its FIFOs.
// Assumes: One clock domain.
// Notes:   store is the FIFO end, user the bridge end.
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 9);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
    modport user  (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data);
endinterface

// ==== logic/sync_fifo.sv ====
// Purpose: Small synchronous FIFO with registered ready and valid.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty are kept as flags so both ends see flops.
`timescale 1ns/1ns
module sync_fifo
    import bridge_pkg::*;
#(
    parameter int W     = 9,
    parameter int DEPTH = 8
)(
    // Clock and reset
    input  logic     pclk,
    input  logic     presetn,
    // Stream ends
    fifo_if.store    port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    rdy;
        logic                    vld;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    assign push          = port.in_valid & s_q.rdy;
    assign pop           = s_q.vld & port.out_ready;
    assign port.in_ready = s_q.rdy;
    assign port.out_valid = s_q.vld;
    assign port.out_data = s_q.mem[s_q.rd];

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = port.in_data;
            s_d.wr = s_q.wr + AW'(1);
        end
        if (pop)
        begin
            s_d.rd = s_q.rd + AW'(1);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.rdy = s_d.cnt != (AW+1)'(DEPTH);
        s_d.vld = s_d.cnt != '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q     <= '0;
            s_q.rdy <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    a_fifo_count_max: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.cnt <= (AW+1)'(DEPTH))
        else $error("FIFO count above depth.");
    a_fifo_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.rdy == (s_q.cnt != (AW+1)'(DEPTH)))
        else $error("FIFO ready disagrees with count.");
endmodule

// ==== logic/io_bridge.sv ====
// Purpose: Copies cyclic output data of each network into the input
//          image produced on the other network, with APB control.
// Assumes: presetn comes from the A side supply; rx and rd ports come
//          from network engines on pclk; pins and switches are async.
// Notes:   The rules that this block carries out follow.
`timescale 1ns/1ns
module io_bridge
    import bridge_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)(
    // Clock and reset
    input  logic             pclk,
    input  logic             presetn,
    // APB slave
    input  logic             psel,
    input  logic             penable,
    input  logic             pwrite,
    input  logic [7:0]       paddr,
    input  logic [31:0]      pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Switches and bus pins, asynchronous
    input  logic [2:0]       size_sel,
    input  logic [1:0][5:0]  node_sw,
    input  logic [1:0]       can_rx,
    // Consumed output data, one stream per side
    input  logic [1:0]       rx_valid,
    input  logic [1:0]       rx_first,
    input  logic [1:0][7:0]  rx_data,
    output logic [1:0]       rx_ready,
    // Produced input image read port per side
    input  logic [1:0]       rd_en,
    input  logic [1:0][6:0]  rd_addr,
    output logic [1:0][7:0]  rd_data,
    // Node status
    output logic [1:0][5:0]  node_addr,
    output logic [1:0]       baud_done,
    output logic [1:0][1:0]  baud_rate
);
`include "bridge_defines.svh"

    bridge_state_t   s_q;
    bridge_state_t   s_d;
    logic            sw_mode;
    logic [1:0][7:0] xfer_len;
    logic [1:0]      fo_valid;
    logic [1:0][8:0] fo_data;
    logic [1:0]      drain;
    logic            apb_done;

    function automatic logic [7:0] fixed_len(input logic [2:0] sel);
        logic [7:0] v;
        v = `LEN_FIX128;
        unique case (sel)
            `SIZE_SEL_4:   v = `LEN_FIX4;
            `SIZE_SEL_16:  v = `LEN_FIX16;
            `SIZE_SEL_32:  v = `LEN_FIX32;
            default:       v = `LEN_FIX128;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] clamp_len(input logic [31:0] v);
        return (v > {24'h000000, `MAX_LEN}) ? `MAX_LEN : v[7:0];
    endfunction

    // One FIFO per direction; index is the source side.
    fifo_if #(.W(9)) q_if [2] ();

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_dir
            sync_fifo #(
                .W     (9),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .pclk    (pclk),
                .presetn (presetn),
                .port    (q_if[g])
            );
            assign q_if[g].in_valid  = rx_valid[g];
            assign q_if[g].in_data   = {rx_first[g], rx_data[g]};
            // The image port is single ported, so the copy waits while
            // the destination engine reads; the FIFO soaks up the gap.
            assign q_if[g].out_ready = ~rd_en[1-g];
            assign rx_ready[g]       = q_if[g].in_ready;
            assign fo_valid[g]       = q_if[g].out_valid;
            assign fo_data[g]        = q_if[g].out_data;
            assign drain[g]          = fo_valid[g] & ~rd_en[1-g];
        end
    endgenerate

    assign sw_mode     = s_q.size_s2 >= `SIZE_SEL_SW;
    assign xfer_len[0] = sw_mode ? s_q.len_sw[0]
                                 : fixed_len(s_q.size_s2);
    assign xfer_len[1] = sw_mode ? s_q.len_sw[1]
                                 : fixed_len(s_q.size_s2);
    assign apb_done    = psel & penable & s_q.pready;

    always_comb
    begin
        logic [7:0]  idx;
        logic [31:0] rdv;
        logic        bad;
        idx = '0;
        rdv = '0;
        bad = 1'b0;
        s_d = s_q;

        s_d.size_s1  = size_sel;
        s_d.size_s2  = s_q.size_s1;
        s_d.node_s1  = node_sw;
        s_d.node_s2  = s_q.node_s1;
        s_d.node     = s_q.node_s2;
        s_d.pin_s1   = can_rx;
        s_d.pin_s2   = s_q.pin_s1;
        s_d.pin_prev = s_q.pin_s2;

        for (int d = 0; d < 2; d++)
        begin
            // Copy one consumed byte into the opposite produced image.
            if (drain[d])
            begin
                idx = fo_data[d][8] ? 8'h00 : s_q.wptr[d];
                if (idx < xfer_len[d])
                begin
                    s_d.img[1-d][idx[6:0]] = fo_data[d][7:0];
                end
                s_d.wptr[d] = (idx < `MAX_LEN) ? idx + 8'h01 : `MAX_LEN;
                if (fo_data[d][8])
                begin
                    s_d.msg_cnt[d] = s_q.msg_cnt[d] + 16'h0001;
                end
            end

            if (rd_en[d])
            begin
                s_d.rd_data[d] = s_q.img[d][rd_addr[d]];
            end

            // Shortest low run over a fixed number of pulses sets the rate.
            unique case (s_q.bd_st[d])
                BD_WAIT:
                begin
                    if (s_q.pin_prev[d] && !s_q.pin_s2[d])
                    begin
                        s_d.bd_st[d] = BD_MEAS;
                        s_d.run[d]   = 11'h001;
                    end
                end
                BD_MEAS:
                begin
                    if (!s_q.pin_s2[d] && s_q.run[d] != `RUN_MAX)
                    begin
                        s_d.run[d] = s_q.run[d] + 11'h001;
                    end
                    if (s_q.pin_s2[d] && !s_q.pin_prev[d])
                    begin
                        s_d.run[d]   = '0;
                        s_d.edges[d] = s_q.edges[d] + 5'h01;
                        if (s_q.run[d] < s_q.run_min[d])
                        begin
                            s_d.run_min[d] = s_q.run[d];
                        end
                        if (s_q.edges[d] == `BAUD_EDGES - 5'h01)
                        begin
                            s_d.bd_st[d] = BD_DONE;
                            if (s_d.run_min[d] > 11'(`BAUD_SLOW_CYC))
                            begin
                                s_d.rate[d] = RATE_125K;
                            end
                            else if (s_d.run_min[d] > 11'(`BAUD_MID_CYC))
                            begin
                                s_d.rate[d] = RATE_250K;
                            end
                            else
                            begin
                                s_d.rate[d] = RATE_500K;
                            end
                        end
                    end
                end
                BD_DONE:
                begin
                    s_d.bd_st[d] = BD_DONE;
                end
                default:
                begin
                    s_d.bd_st[d] = BD_WAIT;
                end
            endcase
        end

        // APB: one wait state, then pready for a single cycle.
        s_d.pready = psel & penable & ~s_q.pready;
        unique case (paddr)
            `REG_LEN_AB: rdv = {24'h000000, s_q.len_sw[0]};
            `REG_LEN_BA: rdv = {24'h000000, s_q.len_sw[1]};
            `REG_STATUS: rdv = {10'h000, s_q.node[1], s_q.node[0],
                                s_q.rate[1], s_q.bd_st[1] == BD_DONE,
                                s_q.rate[0], s_q.bd_st[0] == BD_DONE,
                                sw_mode, s_q.size_s2};
            `REG_COUNT:  rdv = {s_q.msg_cnt[1], s_q.msg_cnt[0]};
            default:     bad = 1'b1;
        endcase
        if (s_d.pready)
        begin
            s_d.prdata  = pwrite ? 32'h00000000 : rdv;
            s_d.pslverr = bad;
        end
        if (apb_done && pwrite && !bad)
        begin
            if (paddr == `REG_LEN_AB)
            begin
                s_d.len_sw[0] = clamp_len(pwdata);
            end
            if (paddr == `REG_LEN_BA)
            begin
                s_d.len_sw[1] = clamp_len(pwdata);
            end
        end
    end

    // The only reset is the A side supply reset, so it clears both sides.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q         <= '0;
            s_q.run_min <= {`RUN_MAX, `RUN_MAX};
            s_q.rate[0] <= RATE_NONE;
            s_q.rate[1] <= RATE_NONE;
            s_q.len_sw  <= {`LEN_RESET, `LEN_RESET};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign rd_data = s_q.rd_data;
    assign node_addr = s_q.node;
    assign baud_done = {s_q.bd_st[1] == BD_DONE, s_q.bd_st[0] == BD_DONE};
    assign baud_rate = s_q.rate;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The checks watch registered state. The node checks start only once
    // reset is seen high, because the synchroniser is cleared by reset.

    a_copy_a_to_b: assert property (
        drain[0] && fo_data[0][8] && xfer_len[0] != 8'h00
        |=> s_q.img[1][0] == $past(fo_data[0][7:0]))
        else $error("A output byte not copied to B image.");

    a_copy_b_to_a: assert property (
        drain[1] && fo_data[1][8] && xfer_len[1] != 8'h00
        |=> s_q.img[0][0] == $past(fo_data[1][7:0]))
        else $error("B output byte not copied to A image.");

    a_drop_past_len: assert property (
        drain[0] && !fo_data[0][8] && s_q.wptr[0] >= xfer_len[0]
        |=> $stable(s_q.img[1]))
        else $error("Byte beyond the length reached the B image.");

    a_fixed_same_len: assert property (
        !sw_mode |-> xfer_len[0] == xfer_len[1]
            && xfer_len[0] == ((s_q.size_s2 == `SIZE_SEL_4)  ? `LEN_FIX4  :
                               (s_q.size_s2 == `SIZE_SEL_16) ? `LEN_FIX16 :
                               (s_q.size_s2 == `SIZE_SEL_32) ? `LEN_FIX32 :
                                                               `LEN_FIX128))
        else $error("Fixed size differs from the selector setting.");

    a_sw_len_range: assert property (
        apb_done && pwrite && paddr == `REG_LEN_AB
        |=> s_q.len_sw[0] <= `MAX_LEN
            && (s_q.len_sw[0] == $past(pwdata[7:0])
                || $past(pwdata) > 32'h00000080))
        else $error("Software length not taken or not clamped.");

    a_sw_len_ba: assert property (
        apb_done && pwrite && paddr == `REG_LEN_BA
        |=> s_q.len_sw[1] <= `MAX_LEN
            && (s_q.len_sw[1] == $past(pwdata[7:0])
                || $past(pwdata) > 32'h00000080))
        else $error("Software length B not taken or not clamped.");

    a_zero_until_data: assert property (
        s_q.msg_cnt[0] == 16'h0000 && !$past(drain[0]) |-> s_q.img[1] == '0)
        else $error("B image not zero before first A data.");

    a_node_a_follow: assert property (
        presetn ##0 $stable(node_sw[0]) [*3]
        |=> node_addr[0] == $past(node_sw[0], 3))
        else $error("Node address A does not follow its switch.");

    a_node_b_follow: assert property (
        presetn ##0 $stable(node_sw[1]) [*3]
        |=> node_addr[1] == $past(node_sw[1], 3))
        else $error("Node address B does not follow its switch.");

    a_baud_hold: assert property (
        baud_done[0] |=> baud_done[0] && $stable(baud_rate[0]))
        else $error("Detected rate A changed after startup.");

    a_baud_b_hold: assert property (
        baud_done[1] |=> baud_done[1] && $stable(baud_rate[1]))
        else $error("Detected rate B changed after startup.");

    a_read_port: assert property (
        rd_en[1] |=> rd_data[1] == $past(s_q.img[1][rd_addr[1]]))
        else $error("Image read returned wrong byte.");

    a_read_beats_copy: assert property (
        rd_en[1] |=> $stable(s_q.img[1]))
        else $error("Copy into B image during a read.");

    a_apb_pulse: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB ready not a one cycle answer.");

    a_bad_addr_err: assert property (
        psel && penable && !pready && paddr[7:4] != 4'h0
        |=> pslverr && prdata == 32'h00000000)
        else $error("Unmapped address not refused.");

    // A full FIFO is the only way a scanner is ever held off.
    c_fifo_full: cover property (!rx_ready[0]);
    c_copy_a_b: cover property (drain[0] && fo_data[0][8]);
    c_copy_b_a: cover property (drain[1] && fo_data[1][8]);
    c_baud_both: cover property (baud_done == 2'b11);
    c_apb_write: cover property (apb_done && pwrite);
endmodule

// ==== verif/scanner_model.sv ====
// Purpose: Scanner side of one network: output bytes and bus pin.
// Assumes: Everything changes just after pclk rising edges.
// Notes:   Idle data shows the inverse of the last byte, so a stale
//          byte can never pass for a fresh one.
`timescale 1ns/1ns
module scanner_model (
    // Clock
    input  wire logic  pclk,
    // Output byte stream
    output logic       rx_valid,
    output logic       rx_first,
    output logic [7:0] rx_data,
    input  wire logic  rx_ready,
    // Bus receive pin, idle high
    output logic       can_rx
);
    initial
    begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data  = 8'hFF;
        can_rx   = 1'b1;
    end

    task automatic send(input int n, input logic [7:0] sd);
        @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            rx_valid <= 1'b1;
            rx_first <= (i == 0);
            rx_data  <= sd ^ 8'(i);
            do @(posedge pclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_data  <= ~(sd ^ 8'(n - 1));
    endtask

    // Seventeen low pulses; the detector counts sixteen, the first being the pulse that starts it.
    task automatic pulses(input int low);
        for (int i = 0; i < 17; i++)
        begin
            @(posedge pclk);
            can_rx <= 1'b0;
            repeat (low) @(posedge pclk);
            can_rx <= 1'b1;
            repeat (low) @(posedge pclk);
        end
    endtask
endmodule

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the I/O data bridge.
// Assumes: 100 MHz pclk, one APB master, one scanner model per side.
// Notes:   Each message gets a fixed drain allowance before checks.
`timescale 1ns/1ns
`include "bridge_defines.svh"
module tb;
    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [7:0]      paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [2:0]      size_sel;
    logic [1:0][5:0] node_sw;
    logic [1:0][5:0] node_addr;
    wire  [1:0]      can_rx;
    wire  [1:0]      rx_valid;
    wire  [1:0]      rx_first;
    wire  [1:0]      rx_ready;
    wire  [1:0][7:0] rx_data;
    logic [1:0]      rd_en;
    logic [1:0][6:0] rd_addr;
    logic [1:0][7:0] rd_data;
    logic [1:0]      baud_done;
    logic [1:0][1:0] baud_rate;
    logic [7:0]      img_e [2][128];
    logic [15:0]     cnt_e [2];
    logic [31:0]     rv;
    logic [31:0]     st;
    logic            re;
    int              len_e [2];
    int              err_total;
    int              compares;
    int              cycles;
    int              lens [4];

    io_bridge dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .size_sel(size_sel), .node_sw(node_sw),
        .can_rx(can_rx), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_data(rx_data), .rx_ready(rx_ready), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .node_addr(node_addr),
        .baud_done(baud_done), .baud_rate(baud_rate));
    scanner_model pa (.pclk(pclk), .rx_valid(rx_valid[0]),
        .rx_first(rx_first[0]), .rx_data(rx_data[0]),
        .rx_ready(rx_ready[0]), .can_rx(can_rx[0]));
    scanner_model pb (.pclk(pclk), .rx_valid(rx_valid[1]),
        .rx_first(rx_first[1]), .rx_data(rx_data[1]),
        .rx_ready(rx_ready[1]), .can_rx(can_rx[1]));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_total++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdi(input int s, input int a);
        @(posedge pclk);
        rd_en[s]   <= 1'b1;
        rd_addr[s] <= 7'(a);
        @(posedge pclk);
        rd_en[s] <= 1'b0;
        @(posedge pclk);
        chk($sformatf("image%0d[%0d]", s, a), 32'(img_e[s][a]),
            32'(rd_data[s]));
    endtask

    // Checks the first and last byte in range and the first beyond it.
    task automatic edges(input int s, input int l);
        rdi(s, 0);
        rdi(s, l - 1);
        if (l < 128)
            rdi(s, l);
    endtask

    task automatic msg(input int s, input int n, input logic [7:0] sd);
        if (s == 0)
            pa.send(n, sd);
        else
            pb.send(n, sd);
        for (int i = 0; i < n && i < len_e[s]; i++)
            img_e[1 - s][i] = sd ^ 8'(i);
        cnt_e[s]++;
        repeat (12) @(posedge pclk);
    endtask

    task automatic clr;
        foreach (img_e[s, i])
            img_e[s][i] = 8'h00;
        cnt_e[0] = 16'h0000;
        cnt_e[1] = 16'h0000;
    endtask

    initial
    begin
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        size_sel = `SIZE_SEL_4;
        node_sw  = {6'h2A, 6'h05};
        rd_en    = 2'b00;
        rd_addr  = {7'h00, 7'h00};
        lens     = '{`LEN_FIX4, `LEN_FIX16, `LEN_FIX32, `LEN_FIX128};
        clr();
        repeat (10) @(posedge pclk);
        chk("rx_ready", 32'h3, 32'(rx_ready));
        chk("baud_rate", 32'hA, 32'(baud_rate));
        presetn <= 1'b1;
        apb(1'b0, `REG_COUNT, 32'h0);
        chk("count", 32'h0, rv);
        rdi(1, 0);
        rdi(0, 127);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            size_sel <= 3'(k);
            repeat (4) @(posedge pclk);
            len_e[0] = lens[k];
            len_e[1] = lens[k];
            msg(0, (lens[k] < 128) ? lens[k] + 1 : 128, 8'(16 * k + 1));
            msg(1, (lens[k] < 128) ? lens[k] + 1 : 128, 8'(16 * k + 8));
            edges(1, lens[k]);
            edges(0, lens[k]);
        end
        apb(1'b0, `REG_COUNT, 32'h0);
        chk("count", {cnt_e[1], cnt_e[0]}, rv);
        $display("test fixed sizes done");
        size_sel <= `SIZE_SEL_SW;
        // Side A sends 2 and takes 12, so side B is set the other way.
        apb(1'b1, `REG_LEN_AB, 32'h2);
        apb(1'b1, `REG_LEN_BA, 32'hC);
        len_e[0] = 2;
        len_e[1] = 12;
        msg(0, 5, 8'hA0);
        msg(1, 13, 8'hB0);
        edges(1, 2);
        edges(0, 12);
        apb(1'b1, `REG_LEN_AB, 32'h0);
        len_e[0] = 0;
        msg(0, 3, 8'hE0);
        rdi(1, 0);
        apb(1'b1, `REG_LEN_BA, 32'h1FF);
        apb(1'b0, `REG_LEN_BA, 32'h0);
        chk("len_ba", 32'(`MAX_LEN), rv);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("status mode", 32'hC, 32'(rv[3:0]));
        size_sel <= 3'h7;
        repeat (4) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        st = rv;
        chk("status mode", 32'hF, 32'(rv[3:0]));
        $display("test software sizes done");
        apb(1'b1, 8'h10, 32'h5A5A_5A5A);
        chk("wr slverr", 32'h1, 32'(re));
        apb(1'b0, 8'h10, 32'h0);
        chk("rd slverr", 32'h1, 32'(re));
        chk("rd data", 32'h0, rv);
        apb(1'b1, `REG_STATUS, 32'h0);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("status", st, rv);
        $display("test apb done");
        chk("node", 32'({6'h2A, 6'h05}), 32'(node_addr));
        node_sw[0] <= 6'h3F;
        repeat (4) @(posedge pclk);
        chk("node", 32'({6'h2A, 6'h3F}), 32'(node_addr));
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("status node", 32'({6'h2A, 6'h3F}), 32'(rv[21:10]));
        $display("test node done");
        size_sel <= `SIZE_SEL_16;
        repeat (4) @(posedge pclk);
        len_e[0] = 16;
        len_e[1] = 16;
        // Reads on side B stall the drain, so the FIFO has to fill.
        fork
            begin
                @(posedge pclk);
                rd_en[1] <= 1'b1;
                repeat (40) @(posedge pclk);
                chk("full", 32'h0, 32'(rx_ready[0]));
                rd_en[1] <= 1'b0;
            end
            msg(0, 12, 8'h70);
        join
        chk("rx_ready", 32'h3, 32'(rx_ready));
        rdi(1, 11);
        rdi(1, 12);
        $display("test fifo done");
        chk("baud_rate", 32'hA, 32'(baud_rate));
        fork
            pa.pulses(800);
            pb.pulses(100);
        join
        repeat (10) @(posedge pclk);
        chk("baud_done", 32'h3, 32'(baud_done));
        chk("baud_rate", 32'({2'b11, 2'b00}), 32'(baud_rate));
        apb(1'b0, `REG_STATUS, 32'h0);
        // B rate 11 and done, A rate 00 and done.
        chk("status rate", 32'h39, 32'(rv[9:4]));
        $display("test rate done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        clr();
        chk("baud_rate", 32'hA, 32'(baud_rate));
        apb(1'b0, `REG_LEN_BA, 32'h0);
        chk("len_ba", 32'h0, rv);
        apb(1'b0, `REG_COUNT, 32'h0);
        chk("count", 32'h0, rv);
        rdi(0, 0);
        rdi(1, 11);
        $display("test mid reset done");
        results();
    end
endmodule
